// *** saia_pkg.sv ***
// Constants, register map and mode codes for the servo axis interlock block
package saia_pkg;

  // Register port geometry
  localparam int          ADDR_W           = 5;
  localparam int          DATA_W           = 32;

  // Register byte offsets
  localparam logic [4:0]  OFF_CTRL         = 5'h00;
  localparam logic [4:0]  OFF_FAULT        = 5'h04;
  localparam logic [4:0]  OFF_ALARM        = 5'h08;
  localparam logic [4:0]  OFF_STATUS       = 5'h0C;
  localparam logic [4:0]  OFF_MASK         = 5'h10;
  localparam logic [4:0]  OFF_POS          = 5'h14;
  localparam logic [4:0]  OFF_IDX_POS      = 5'h18;
  localparam logic [4:0]  OFF_INPUTS       = 5'h1C;

  // Field layout of the control register
  localparam int          CTRL_MODE_LSB    = 0;
  localparam int          MODE_W           = 3;

  // Event bits of status and mask
  localparam int          EVT_W            = 3;
  localparam int          EVT_FAULT        = 0;
  localparam int          EVT_INDEX        = 1;
  localparam int          EVT_QUAD_ERR     = 2;

  // Alarm value while the drive is not ready: tens digit one
  localparam logic [4:0]  ALARM_BASE       = 5'h0A;
  localparam int          CODE_W           = 3;

  // Raw pin bundle order seen by the synchroniser
  localparam int          PIN_W            = 7;
  localparam int          PIN_READY        = 0;
  localparam int          PIN_CODE_LSB     = 1;
  localparam int          PIN_A            = 4;
  localparam int          PIN_B            = 5;
  localparam int          PIN_Z            = 6;

  // Alarm clear hold time, least time, rounded up to cycles
  localparam int          CLK_PERIOD_NS    = 100;
  localparam int          ALM_CLR_TIME_US  = 1000;
  localparam int          ALM_CLR_CYCLES   = (ALM_CLR_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CLR_CNT_W        = 24;

  // Operating modes of the axis
  typedef enum logic [2:0] {
    MODE_OFF      = 3'b000,
    MODE_STANDBY  = 3'b001,
    MODE_OUTPUT   = 3'b010,
    MODE_VELOCITY = 3'b011,
    MODE_POSITION = 3'b100
  } saia_mode_e;

endpackage

// *** saia_if.sv ***
// Bundle between the pin synchroniser, the encoder decoder and the axis core
`timescale 1ns/100ps
interface saia_if;
  logic       ready;       // Filtered drive-ready interlock, high = asserted
  logic [2:0] code;        // Filtered three-line alarm code
  logic       enc_a;       // Filtered encoder channel a
  logic       enc_b;       // Filtered encoder channel b
  logic       enc_z;       // Filtered index marker
  logic       step_up;     // One-cycle count up pulse
  logic       step_dn;     // One-cycle count down pulse
  logic       index_seen;  // One-cycle pulse on marker rising edge
  logic       quad_err;    // One-cycle pulse when both channels jump

  modport sync (output ready, code, enc_a, enc_b, enc_z);
  modport dec  (input enc_a, enc_b, enc_z, output step_up, step_dn, index_seen, quad_err);
  modport core (input ready, code, step_up, step_dn, index_seen, quad_err, enc_a, enc_b, enc_z);
endinterface

// *** saia_sync.sv ***
// Three-stage synchroniser with agreement filter for the opto and encoder pins
`timescale 1ns/100ps
module saia_sync (
  input  wire logic                       clock,
  input  wire logic                       resetn,
  input  wire logic [saia_pkg::PIN_W-1:0] pins_raw,
  saia_if.sync                            ax
);

  // Whole state of the synchroniser
  typedef struct packed {
    logic [saia_pkg::PIN_W-1:0] s1;  // First stage, read only by the second
    logic [saia_pkg::PIN_W-1:0] s2;  // Second stage
    logic [saia_pkg::PIN_W-1:0] s3;  // Third stage
    logic [saia_pkg::PIN_W-1:0] f;   // Accepted level
  } saia_sync_s;

  saia_sync_s q;
  saia_sync_s d;

  // Shift pins in; accept a level only when stages two and three agree [RULE11]
  always_comb begin
    d    = q;
    d.s1 = pins_raw;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.f  = (q.s3 & ~(q.s2 ^ q.s3)) | (q.f & (q.s2 ^ q.s3));
  end

  // State register, synchronous reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Hand the accepted levels out
  assign ax.ready = q.f[saia_pkg::PIN_READY];
  assign ax.code  = q.f[saia_pkg::PIN_CODE_LSB +: saia_pkg::CODE_W];
  assign ax.enc_a = q.f[saia_pkg::PIN_A];
  assign ax.enc_b = q.f[saia_pkg::PIN_B];
  assign ax.enc_z = q.f[saia_pkg::PIN_Z];

endmodule

// *** saia_quad.sv ***
// Quadrature x4 decoder with index marker edge detect
`timescale 1ns/100ps
module saia_quad (
  input  wire logic clock,
  input  wire logic resetn,
  saia_if.dec       ax
);

  // Previous encoder levels
  typedef struct packed {
    logic a;  // Channel a one cycle ago
    logic b;  // Channel b one cycle ago
    logic z;  // Marker one cycle ago
  } saia_quad_s;

  saia_quad_s q;
  saia_quad_s d;
  logic       a_chg;  // Channel a moved
  logic       b_chg;  // Channel b moved

  // Remember last levels
  always_comb begin
    d   = q;
    d.a = ax.enc_a;
    d.b = ax.enc_b;
    d.z = ax.enc_z;
  end

  // State register, synchronous reset
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Direction from phase: a leading b counts up [RULE8]
  assign a_chg         = ax.enc_a ^ q.a;
  assign b_chg         = ax.enc_b ^ q.b;
  assign ax.step_up    = (a_chg & ~b_chg & (ax.enc_a ^ ax.enc_b)) |
                         (b_chg & ~a_chg & ~(ax.enc_a ^ ax.enc_b));
  assign ax.step_dn    = (a_chg & ~b_chg & ~(ax.enc_a ^ ax.enc_b)) |
                         (b_chg & ~a_chg & (ax.enc_a ^ ax.enc_b));
  assign ax.quad_err   = a_chg & b_chg;
  // Once-per-revolution marker rising edge [RULE9]
  assign ax.index_seen = ax.enc_z & ~q.z;

endmodule

// *** saia_top.sv ***
// Servo axis interlock, alarm and encoder front end with register port
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/100ps
//
// Function
// RULE1: Torque permit on only in torque-producing modes
// RULE2: Writing zero to fault pulses alarm clear
// RULE3: Drive clears alarms while clear held
// RULE4: Three alarm lines read as one code
// RULE5: Alarm code forms units digit of alarm
// RULE6: Modes blocked while drive-ready is low
// RULE7: Not ready reports alarm ten plus code
// RULE8: Quadrature channels decoded into position count
// RULE9: Index channel treated as revolution marker
// RULE10: Direction permits tied active outside logic
// RULE11: All pins pass a synchroniser first
// RULE12: Ready drop kills torque, latches fault; the code latches the fault only while the running mode is not off
module saia_top #(
  parameter int unsigned ALM_CLR_CYCLES = saia_pkg::ALM_CLR_CYCLES  // Alarm clear hold length
) (
  input  wire logic                        clock,
  input  wire logic                        resetn,
  input  wire logic [saia_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [saia_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [saia_pkg::DATA_W-1:0] reg_rdata,
  output logic                             irq,
  input  wire logic                        encoder_channel_a,
  input  wire logic                        encoder_channel_b,
  input  wire logic                        encoder_index_marker,
  input  wire logic                        alarm_code_bit0,
  input  wire logic                        alarm_code_bit1,
  input  wire logic                        alarm_code_bit2,
  input  wire logic                        drive_ready_in,
  output logic                             torque_permit_out,
  output logic                             drive_alarm_clear_out,
  output logic      [saia_pkg::MODE_W-1:0] axis_mode,
  output logic      [saia_pkg::DATA_W-1:0] position_count
);

  // Whole state of the axis core
  // One packed word, so one flop process holds it all
  typedef struct packed {
    saia_pkg::saia_mode_e               mode_req;   // Mode software asked for
    saia_pkg::saia_mode_e               mode_eff;   // Mode actually running
    logic                               fault;      // Latched interlock fault
    logic                               ready_q;    // Ready one cycle ago
    logic                               torque;     // Torque permit output
    logic                               clr_out;    // Alarm clear output
    logic [saia_pkg::CLR_CNT_W-1:0]     clr_cnt;    // Cycles left of alarm clear
    logic [saia_pkg::EVT_W-1:0]         status;     // Sticky events
    logic [saia_pkg::EVT_W-1:0]         mask;       // Interrupt enables
    logic [saia_pkg::DATA_W-1:0]        pos;        // Position count
    logic [saia_pkg::DATA_W-1:0]        idx_pos;    // Count caught at marker
    logic [saia_pkg::DATA_W-1:0]        rdata;      // Read data register
  } saia_top_s;

  // Core state and its next value
  saia_top_s                      q;            // Current state
  saia_top_s                      d;            // Next state
  logic [saia_pkg::PIN_W-1:0]     pins_raw;     // Raw pin bundle
  logic [saia_pkg::EVT_W-1:0]     evt;          // Events seen this cycle
  logic [saia_pkg::DATA_W-1:0]    alarm_val;    // Alarm value for software
  logic                           ready_fall;   // Drive-ready dropped
  logic                           wr_fault;     // Write to fault register
  logic                           clr_req;      // Zero written to fault
  logic                           torque_mode;  // Mode produces torque
  saia_pkg::saia_mode_e           mode_wr;      // Decoded written mode
  logic                           mode_ok;      // Written code is legal

  // Bundle shared by synchroniser, decoder and core
  saia_if ax ();

  // Gather the pins; the alarm code lines form one value [RULE4]
  // Order follows the pin positions of the package
  assign pins_raw = {encoder_index_marker, encoder_channel_b, encoder_channel_a,
                     alarm_code_bit2, alarm_code_bit1, alarm_code_bit0, drive_ready_in};

  // Pin synchroniser [RULE11]
  // Three stages and an agreement filter per pin
  saia_sync u_sync (
    .clock    (clock),
    .resetn   (resetn),
    .pins_raw (pins_raw),
    .ax       (ax.sync)
  );

  // Encoder decoder
  // Steps and marker edge from filtered levels
  saia_quad u_quad (
    .clock  (clock),
    .resetn (resetn),
    .ax     (ax.dec)
  );

  // Alarm value: ten plus code while not ready, else zero [RULE7]
  always_comb begin
    // No alarm while the drive reports ready
    alarm_val = '0;
    // Not ready: tens digit one
    if (!ax.ready) begin
      // Code lands in the units digit [RULE5]
      alarm_val[4:0] = saia_pkg::ALARM_BASE + {2'h0, ax.code};
    end
  end

  // Decode a mode code written by software
  always_comb begin
    // Legal unless the default arm says otherwise
    mode_ok = 1'b1;
    // Off unless a legal code names another mode
    mode_wr = saia_pkg::MODE_OFF;
    unique case (reg_wdata[saia_pkg::CTRL_MODE_LSB +: saia_pkg::MODE_W])
      3'h0:    mode_wr = saia_pkg::MODE_OFF;
      3'h1:    mode_wr = saia_pkg::MODE_STANDBY;
      3'h2:    mode_wr = saia_pkg::MODE_OUTPUT;
      3'h3:    mode_wr = saia_pkg::MODE_VELOCITY;
      3'h4:    mode_wr = saia_pkg::MODE_POSITION;
      // Unused codes are ignored
      default: mode_ok = 1'b0;
    endcase
  end

  // Event and strobe terms
  // Falling edge of the filtered ready level
  assign ready_fall = q.ready_q & ~ax.ready;
  // Any write that lands on the fault register
  assign wr_fault   = reg_wr & (reg_addr == saia_pkg::OFF_FAULT);
  // Only an all-zero word asks for the alarm clear
  assign clr_req    = wr_fault & (reg_wdata == '0);

  // Next state of the whole core
  always_comb begin
    // Hold everything by default
    d         = q;
    // Remember ready for the edge detect
    d.ready_q = ax.ready;
    // Read data lasts one cycle only
    d.rdata   = '0;
    // No events unless seen below
    evt       = '0;

    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        saia_pkg::OFF_CTRL: begin
          // Illegal codes leave the request alone
          if (mode_ok) begin
            d.mode_req = mode_wr;
          end
        end
        saia_pkg::OFF_STATUS: begin
          // Write one to clear
          d.status = q.status & ~reg_wdata[saia_pkg::EVT_W-1:0];
        end
        saia_pkg::OFF_MASK: begin
          // Plain write of the enables
          d.mask = reg_wdata[saia_pkg::EVT_W-1:0];
        end
        saia_pkg::OFF_POS: begin
          // Software load of the count
          d.pos = reg_wdata;
        end
        default: begin
          // Fault is handled below; read-only or unmapped: no effect
        end
      endcase
    end

    // Zero to fault clears the latch and starts alarm clear [RULE2]
    if (clr_req) begin
      d.fault   = 1'b0;
      // A new zero write restarts the hold
      d.clr_cnt = ALM_CLR_CYCLES[saia_pkg::CLR_CNT_W-1:0];
    end else if (q.clr_cnt != '0) begin
      // Count the hold down to zero
      d.clr_cnt = q.clr_cnt - 1'b1;
    end
    // Clear stays high for the whole hold time [RULE3]
    // Taken from the next count, so no extra lag
    d.clr_out = (d.clr_cnt != '0);

    // Ready drop while running latches a fault; set beats clear [RULE12]
    if (ready_fall && q.mode_eff != saia_pkg::MODE_OFF) begin
      // Latch until software writes zero
      d.fault              = 1'b1;
      // Forget the request so torque stays off
      d.mode_req           = saia_pkg::MODE_OFF;
      // Flag the fault to software
      evt[saia_pkg::EVT_FAULT] = 1'b1;
    end

    // Modes only run with ready asserted and no fault [RULE6]
    if (ax.ready && !d.fault) begin
      // Drive ready and no fault: run the request
      d.mode_eff = d.mode_req;
    end else begin
      // Blocked: report off
      d.mode_eff = saia_pkg::MODE_OFF;
    end

    // Torque permit only in torque-producing modes [RULE1]
    // Standby holds the loop but gives no torque
    torque_mode = (d.mode_eff == saia_pkg::MODE_OUTPUT) ||
                  (d.mode_eff == saia_pkg::MODE_VELOCITY) ||
                  (d.mode_eff == saia_pkg::MODE_POSITION);
    // Drops in the same cycle the ready loss is seen [RULE12]
    d.torque = torque_mode & ax.ready;

    // Position count, unless software is loading it [RULE8]
    if (!(reg_wr && reg_addr == saia_pkg::OFF_POS)) begin
      // Count wraps at both ends
      if (ax.step_up) begin
        // Forward step
        d.pos = q.pos + 1'b1;
      end else if (ax.step_dn) begin
        // Reverse step
        d.pos = q.pos - 1'b1;
      end
    end

    // Marker latches the count and flags an event [RULE9]
    if (ax.index_seen) begin
      // Count as it stood before this cycle
      d.idx_pos                = q.pos;
      // Flag the marker to software
      evt[saia_pkg::EVT_INDEX] = 1'b1;
    end
    // Both channels moved at once: counts lost
    // Sign of a pin moving faster than the filter
    evt[saia_pkg::EVT_QUAD_ERR] = ax.quad_err;

    // New events set after any clear, so they are never lost
    // A set in the same cycle as a clear wins
    d.status = d.status | evt;

    // Read data, valid the cycle after the strobe
    // Reads have no side effects
    if (reg_rd) begin
      unique case (reg_addr)
        saia_pkg::OFF_CTRL: begin
          // Requested mode low, running mode above
          d.rdata[saia_pkg::CTRL_MODE_LSB +: saia_pkg::MODE_W] = q.mode_req;
          d.rdata[saia_pkg::MODE_W +: saia_pkg::MODE_W]        = q.mode_eff;
        end
        saia_pkg::OFF_FAULT: begin
          // Latched fault in the lowest bit
          d.rdata[0] = q.fault;
        end
        saia_pkg::OFF_ALARM: begin
          // Live alarm value
          d.rdata = alarm_val;
        end
        saia_pkg::OFF_STATUS: begin
          // Sticky events
          d.rdata[saia_pkg::EVT_W-1:0] = q.status;
        end
        saia_pkg::OFF_MASK: begin
          // Interrupt enables
          d.rdata[saia_pkg::EVT_W-1:0] = q.mask;
        end
        saia_pkg::OFF_POS: begin
          // Live count
          d.rdata = q.pos;
        end
        saia_pkg::OFF_IDX_POS: begin
          // Count caught at the last marker
          d.rdata = q.idx_pos;
        end
        saia_pkg::OFF_INPUTS: begin
          // Filtered pins and both outputs
          d.rdata[saia_pkg::PIN_W-1:0] = {ax.enc_z, ax.enc_b, ax.enc_a, ax.code, ax.ready};
          d.rdata[saia_pkg::PIN_W]     = q.torque;
          d.rdata[saia_pkg::PIN_W+1]   = q.clr_out;
        end
        default: begin
          // Unmapped reads as zero
          d.rdata = '0;
        end
      endcase
    end
  end

  // State register, synchronous reset
  // Reset leaves the axis off with count zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops, interrupt from the masked status
  assign reg_rdata             = q.rdata;
  assign torque_permit_out     = q.torque;        // [RULE1]
  assign drive_alarm_clear_out = q.clr_out;       // [RULE2]
  // Mode and count for the axis loop
  assign axis_mode             = q.mode_eff;
  assign position_count        = q.pos;
  // Level interrupt while an enabled event stands
  assign irq                   = |(q.status & q.mask);

endmodule

// *** saia_top_properties.sv ***
// Checker of torque, alarm clear, alarm value and count behaviour at the top ports
`timescale 1ns/100ps
module saia_top_properties #(
  parameter int unsigned ALM_CLR_CYCLES = 8  // Alarm clear hold length
) (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [4:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        alarm_code_bit0,
  input wire logic        alarm_code_bit1,
  input wire logic        alarm_code_bit2,
  input wire logic        drive_ready_in,
  input wire logic        torque_permit_out,
  input wire logic        drive_alarm_clear_out,
  input wire logic [2:0]  axis_mode,
  input wire logic [31:0] position_count
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic        zero_wr;    // Zero written to the fault register
  logic [23:0] clr_cnt_q;  // Cycles the clear has stood
  assign zero_wr = reg_wr && reg_addr == saia_pkg::OFF_FAULT && reg_wdata == 32'h0;
  // Counts clear cycles, restarted by each zero write
  always_ff @(posedge clock) begin
    if (!resetn || zero_wr) begin
      clr_cnt_q <= 24'h0;
    end else if (drive_alarm_clear_out) begin
      clr_cnt_q <= clr_cnt_q + 24'h1;
    end
  end
  // Torque permit present while ready falls
  sequence s_drop;
    torque_permit_out && $fell(drive_ready_in);
  endsequence
  // Alarm read after a settled not-ready interval
  sequence s_nr_read;
    (!drive_ready_in) [*6] ##0 (reg_rd && reg_addr == saia_pkg::OFF_ALARM);
  endsequence
  AST_TORQUE_MODE: assert property (torque_permit_out == (axis_mode inside {3'h2, 3'h3, 3'h4}))
    else $error("torque permit disagrees with mode");
  AST_CLR_START: assert property (zero_wr |=> drive_alarm_clear_out)
    else $error("alarm clear not raised after zero write");
  AST_CLR_CAUSE: assert property ($rose(drive_alarm_clear_out) |-> $past(zero_wr))
    else $error("alarm clear raised without zero write");
  AST_CLR_HOLD: assert property (drive_alarm_clear_out |-> clr_cnt_q < ALM_CLR_CYCLES)
    else $error("alarm clear stands too long");
  AST_CLR_END: assert property ($fell(drive_alarm_clear_out) |-> clr_cnt_q == ALM_CLR_CYCLES)
    else $error("alarm clear ended early");
  AST_NOT_READY_OFF: assert property ((!drive_ready_in) [*6] |-> axis_mode == 3'h0)
    else $error("mode active while not ready");
  AST_DROP_SYNC: assert property (s_drop |-> torque_permit_out [*3])
    else $error("ready pin acted without synchroniser delay");
  AST_DROP_KILL: assert property (s_drop |-> ##[1:8] !torque_permit_out)
    else $error("torque kept after ready drop");
  AST_ALARM_VALUE: assert property (s_nr_read |=> reg_rdata == 32'h0000_000A +
    32'({$past(alarm_code_bit2), $past(alarm_code_bit1), $past(alarm_code_bit0)}))
    else $error("alarm value not ten plus code");
  AST_COUNT_STEP: assert property (!(reg_wr && reg_addr == saia_pkg::OFF_POS) |=>
    (position_count - $past(position_count)) inside {32'h0, 32'h1, 32'hFFFF_FFFF})
    else $error("count jumped more than one");
endmodule
bind saia_top saia_top_properties #(.ALM_CLR_CYCLES(ALM_CLR_CYCLES)) u_saia_top_properties (
  .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .alarm_code_bit0,
  .alarm_code_bit1, .alarm_code_bit2, .drive_ready_in, .torque_permit_out, .drive_alarm_clear_out,
  .axis_mode, .position_count);

// *** saia_drive_model.sv ***
// Behavioural servodrive: interlock lines, alarm code and a stepped encoder
`timescale 1ns/100ps
module saia_drive_model (
  input  wire logic       clock,
  input  wire logic       fault_set,    // Raise an alarm
  input  wire logic [2:0] fault_code,   // Code shown with it
  input  wire logic       step_req,     // One encoder step per pulse
  input  wire logic       step_dir,     // High steps forward
  input  wire logic       alarm_clear,  // Clear request from the axis
  output logic            drive_ready,  // High while no alarm
  output logic [2:0]      code_lines,   // Coded alarm lines
  output logic            enc_a,
  output logic            enc_b,
  output logic            enc_z
);
  logic       alarm_q = 1'b0;  // Alarm latched
  logic [2:0] code_q  = 3'h0;  // Latched code
  logic [3:0] pos_q   = 4'h0;  // Shaft phase count
  logic [3:0] z_dly_q = 4'h0;  // Marker lags the step
  // Alarm latch and encoder stepping
  always @(posedge clock) begin
    if (fault_set) begin
      alarm_q <= 1'b1;
      code_q <= fault_code;
    end else if (alarm_clear) begin
      alarm_q <= 1'b0;
    end
    if (step_req) begin
      pos_q <= step_dir ? pos_q + 4'h1 : pos_q - 4'h1;
    end
    z_dly_q <= {z_dly_q[2:0], pos_q == 4'h8};
  end
  // Direction permits are wired active inside the drive, no pins here
  assign drive_ready = !alarm_q;
  assign code_lines = alarm_q ? code_q : 3'h0;
  assign enc_a = pos_q[0] ^ pos_q[1];
  assign enc_b = pos_q[1];
  assign enc_z = z_dly_q[3];
endmodule

// *** tb_top.sv ***
// Self-checking bench for the servo axis interlock block
`timescale 1ns/100ps
module tb_top;
  typedef struct {logic [2:0] req; logic [2:0] mode; logic torque;} saia_row_s;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata, position_count, rd_q;
  logic        irq, torque, clr, ready, enc_a, enc_b, enc_z;
  logic [2:0]  axis_mode, code;
  logic        fault_set = 1'b0;
  logic [2:0]  fault_code = 3'h0;
  logic        step_req = 1'b0;
  logic        step_dir = 1'b1;
  int          num_errors = 0;
  int          total_checks = 0;
  // Requested mode, mode seen, torque; code 5 is refused
  saia_row_s   rows [6] = '{'{3'h0, 3'h0, 1'b0}, '{3'h1, 3'h1, 1'b0}, '{3'h2, 3'h2, 1'b1},
                            '{3'h3, 3'h3, 1'b1}, '{3'h4, 3'h4, 1'b1}, '{3'h5, 3'h4, 1'b1}};
  saia_top #(.ALM_CLR_CYCLES(8)) u_saia_top (
    .clock, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .encoder_channel_a(enc_a), .encoder_channel_b(enc_b), .encoder_index_marker(enc_z),
    .alarm_code_bit0(code[0]), .alarm_code_bit1(code[1]), .alarm_code_bit2(code[2]),
    .drive_ready_in(ready), .torque_permit_out(torque), .drive_alarm_clear_out(clr),
    .axis_mode, .position_count);
  saia_drive_model u_drive (
    .clock, .fault_set, .fault_code, .step_req, .step_dir, .alarm_clear(clr),
    .drive_ready(ready), .code_lines(code), .enc_a, .enc_b, .enc_z);
  initial begin
    forever #50 clock = ~clock;
  end
  task automatic results();
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  task automatic step(input logic dir);
    @(posedge clock);
    step_req <= 1'b1;
    step_dir <= dir;
    @(posedge clock);
    step_req <= 1'b0;
    cyc(8);
  endtask
  task automatic rst();
    @(posedge clock);
    resetn <= 1'b0;
    cyc(4);
    resetn <= 1'b1;
    cyc(1);
    #1;
    chk("torque_rst", 32'h0, 32'(torque));
    chk("mode_rst", 32'h0, 32'(axis_mode));
    chk("clear_rst", 32'h0, 32'(clr));
    chk("count_rst", 32'h0, position_count);
  endtask
  // Cuts a hang short
  initial begin
    #3_000_000;
    num_errors++;
    results();
  end
  initial begin
    rst();
    cyc(10);
    // Mode table with the drive ready
    foreach (rows[i]) begin
      wr(saia_pkg::OFF_CTRL, 32'(rows[i].req));
      chk("mode", 32'(rows[i].mode), 32'(axis_mode));
      chk("torque", 32'(rows[i].torque), 32'(torque));
    end
    rd(saia_pkg::OFF_CTRL);
    chk("ctrl", 32'h0000_0024, rd_q);
    // Eight steps forward over the marker, two back
    wr(saia_pkg::OFF_MASK, 32'h0000_0003);
    repeat (8) step(1'b1);
    chk("count_up", 32'h0000_0008, position_count);
    repeat (2) step(1'b0);
    chk("count_dn", 32'h0000_0006, position_count);
    wr(saia_pkg::OFF_POS, 32'h0000_0100);
    chk("pos_load", 32'h0000_0100, position_count);
    rd(saia_pkg::OFF_POS);
    chk("pos_rd", 32'h0000_0100, rd_q);
    rd(saia_pkg::OFF_IDX_POS);
    chk("idx_pos", 32'h0000_0008, rd_q);
    rd(saia_pkg::OFF_STATUS);
    chk("status_idx", 32'h0000_0002, rd_q);
    chk("irq_idx", 32'h1, 32'(irq));
    wr(saia_pkg::OFF_STATUS, 32'h0000_0002);
    chk("irq_w1c", 32'h0, 32'(irq));
    // Drive alarm in position mode
    @(posedge clock);
    fault_set <= 1'b1;
    fault_code <= 3'h5;
    @(posedge clock);
    fault_set <= 1'b0;
    for (int i = 0; i < 20 && torque !== 1'b0; i++) @(posedge clock);
    chk("torque_drop", 32'h0, 32'(torque));
    if (torque !== 1'b0) results();
    cyc(2);
    rd(saia_pkg::OFF_FAULT);
    chk("fault", 32'h1, rd_q);
    rd(saia_pkg::OFF_ALARM);
    chk("alarm", 32'h0000_000F, rd_q);
    rd(saia_pkg::OFF_INPUTS);
    chk("code", 32'h0000_000A, rd_q & 32'h0000_000F);
    chk("irq_fault", 32'h1, 32'(irq));
    wr(saia_pkg::OFF_CTRL, 32'h0000_0002);
    chk("mode_blocked", 32'h0, 32'(axis_mode));
    // Zero write clears fault and holds the clear
    wr(saia_pkg::OFF_FAULT, 32'h0);
    chk("clr_on", 32'h1, 32'(clr));
    cyc(7);
    #1 chk("clr_last", 32'h1, 32'(clr));
    cyc(1);
    #1 chk("clr_off", 32'h0, 32'(clr));
    cyc(8);
    rd(saia_pkg::OFF_ALARM);
    chk("alarm_gone", 32'h0, rd_q);
    rd(saia_pkg::OFF_FAULT);
    chk("fault_gone", 32'h0, rd_q);
    wr(saia_pkg::OFF_STATUS, 32'h0000_0001);
    chk("irq_clr", 32'h0, 32'(irq));
    wr(saia_pkg::OFF_CTRL, 32'h0000_0002);
    chk("torque_back", 32'h1, 32'(torque));
    rd(5'h02);
    chk("unmapped", 32'h0, rd_q);
    rst();
    // Both encoder lines rise together after reset: one quadrature error
    cyc(8);
    rd(saia_pkg::OFF_STATUS);
    chk("status_quad", 32'h0000_0004, rd_q);
    results();
  end
endmodule
